// ### core/mwd_params.svh
// Protocol constants of the write-multiple and diagnostics request handler.
`ifndef MWD_PARAMS_SVH
`define MWD_PARAMS_SVH
`define MWD_FC_WR_MULTI   8'h10
`define MWD_FC_DIAG       8'h08
`define MWD_EXC_FLAG      8'h80
`define MWD_ADDR_BCAST    8'h00
`define MWD_MAX_REGS      123
`define MWD_HDR_LEN       8'h07
`define MWD_DIAG_LEN      8'h06
`define MWD_NORM_LAST     3'h5
`define MWD_EXC_LAST      3'h2
`define MWD_EXC_ILL_FUNC  8'h01
`define MWD_EXC_ILL_ADDR  8'h02
`define MWD_EXC_ILL_VALUE 8'h03
`define MWD_EXC_DEV_FAIL  8'h04
`define MWD_EXC_BUSY      8'h06
`define MWD_SUB_CLEAR     8'h0a
`define MWD_SUB_FIRST_CNT 8'h0b
`define MWD_SUB_LAST      8'h12
`define MWD_ADDR_SPAN     17'h10000
`define MWD_DIAG_COMM_BIT 0
`define MWD_DIAG_OVR_BIT  1
`endif

// ### core/mwd_pkg.sv
// Types shared by the write-multiple and diagnostics request handler.
package mwd_pkg;
  typedef enum logic [1:0] {
    MWD_RX    = 2'b00,
    MWD_WRITE = 2'b01,
    MWD_REPLY = 2'b10
  } mwd_state_t;
  // Counter index equals sub-function minus the first counter sub-function.
  typedef enum logic [2:0] {
    MWD_CNT_BUS    = 3'h0,
    MWD_CNT_COMM   = 3'h1,
    MWD_CNT_EXC    = 3'h2,
    MWD_CNT_SRV    = 3'h3,
    MWD_CNT_NORESP = 3'h4,
    MWD_CNT_NAK    = 3'h5,
    MWD_CNT_BUSY   = 3'h6,
    MWD_CNT_OVR    = 3'h7
  } mwd_cnt_t;
endpackage : mwd_pkg

// ### core/mwd_server.sv
// Write-multiple-registers and diagnostics request handler with its reply FIFO.
//
// Contract
// - Function 0x10 writes a contiguous run; counts above 123 are rejected.
// - Sixteen-bit values travel as two bytes, high byte first.
// - A failed write replies 0x90 with exception code 01, 02, 03, 04 or 06.
// - Diagnostics function 0x08 selects its operation by a two-byte sub-function.
// - Sub-function 0x0A zeroes every counter and the diagnostics register, except a flag set by an error event in the same cycle.
// - Sub-function 0x0B returns all requests with a good CRC that end while in MWD_RX, any address.
// - Sub-function 0x0C returns combined CRC, framing and incomplete errors; overruns count only under 0x12.
// - Sub-function 0x0D returns the number of exception replies sent.
// - Sub-function 0x0E returns requests addressed to this device.
// - Sub-function 0x0F returns broadcast write and diagnostics requests, which get no reply.
// - Sub-function 0x10 returns the not-acknowledged count, which nothing increments, so it always reads zero.
// - Sub-function 0x11 returns requests answered with server busy.
// - Sub-function 0x12 returns own requests received with a character overrun.
// - Counters restart from zero at reset, on overflow and on clear.
`include "mwd_params.svh"
`timescale 1ns/100ps
`default_nettype none

// Synchronous FIFO; one slot is never wasted because a count tracks fill.
module mwd_fifo
  import mwd_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Filling side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_chk
    $error("mwd_fifo depth must be a power of two of at least two");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      fill_r;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  // Full and empty come straight from the fill count; an empty buffer must accept.
  assign in_ready_o  = (fill_r < (AW+1)'(DEPTH));
  assign out_valid_o = (fill_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];

  // Storage is written without reset; only pointers and the fill count need a defined value.
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_i;
  end

  // Pointers and fill count.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fill_r   <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      fill_r   <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : mwd_fifo

module mwd_server
  import mwd_pkg::*;
#(
  parameter int MAX_REGS   = `MWD_MAX_REGS,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_I,
  // Own station address and server state.
  input  wire logic [7:0]  DEV_ADDR_I,
  input  wire logic        BUSY_I,
  // Received frame bytes, CRC already checked and stripped upstream.
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_VALID_I,
  input  wire logic        RX_END_I,
  input  wire logic        RX_CRC_OK_I,
  input  wire logic        RX_ERR_I,
  input  wire logic        RX_OVR_I,
  // Register map write port.
  output logic             REG_WE_O,
  output logic [15:0]      REG_ADDR_O,
  output logic [15:0]      REG_DATA_O,
  input  wire logic [7:0]  REG_EXC_I,
  // Reply byte stream towards the CRC appender.
  output logic             TX_VALID_O,
  input  wire logic        TX_READY_I,
  output logic [7:0]       TX_DATA_O,
  output logic             TX_LAST_O,
  // Diagnostics register.
  output logic [15:0]      DIAG_REG_O
);
  localparam int BUF_BYTES = 2 * MAX_REGS;
  if (MAX_REGS < 1 || MAX_REGS > `MWD_MAX_REGS)
  begin : g_chk
    $error("mwd_server MAX_REGS out of range");
  end

  mwd_state_t  state_r;
  mwd_state_t  state_nxt;
  logic [7:0]  hdr_r [7];
  logic [7:0]  buf_r [BUF_BYTES];
  logic [7:0]  rx_cnt_r;
  logic        ovr_seen_r;
  logic [7:0]  rep_code_r;
  logic [15:0] rep_val_r;
  logic        rep_bcast_r;
  logic [2:0]  rep_idx_r;
  logic [6:0]  wr_idx_r;
  logic        wr_issued_r;
  logic [15:0] cnt_r [8];
  logic [7:0]  cnt_inc;
  logic [15:0] diag_r;

  // Header fields; every 16-bit field is high byte first.
  wire [15:0] start_addr = {hdr_r[2], hdr_r[3]};
  wire [15:0] reg_count  = {hdr_r[4], hdr_r[5]};
  wire [15:0] diag_data  = {hdr_r[4], hdr_r[5]};
  wire [7:0]  func       = hdr_r[1];
  wire        is_wr      = (func == `MWD_FC_WR_MULTI);
  wire        is_dg      = (func == `MWD_FC_DIAG);
  wire        addr_hit   = (hdr_r[0] == DEV_ADDR_I);
  wire        bcast      = (hdr_r[0] == `MWD_ADDR_BCAST);

  // Frame end qualification; a bad CRC never reaches the reply path.
  wire frame_end = (state_r == MWD_RX) && RX_END_I;
  wire end_ok    = frame_end && RX_CRC_OK_I;
  wire end_bad   = frame_end && !RX_CRC_OK_I;
  wire for_us    = end_ok && (addr_hit || bcast) && (is_wr || is_dg);

  // Write checks: count range, byte count 2N, frame length and address span.
  wire [8:0]  exp_bytes = {reg_count[7:0], 1'b0};
  wire        cnt_bad   = (reg_count == 16'h0) || (reg_count > 16'(MAX_REGS));
  wire        bc_bad    = ({1'b0, hdr_r[6]} != exp_bytes) ||
                          ({1'b0, rx_cnt_r} != 9'(exp_bytes + 9'(`MWD_HDR_LEN)));
  wire        span_bad  = (17'(start_addr) + 17'(reg_count)) > `MWD_ADDR_SPAN;
  wire [7:0]  wr_exc    = BUSY_I ? `MWD_EXC_BUSY :
                          (cnt_bad || bc_bad) ? `MWD_EXC_ILL_VALUE :
                          span_bad ? `MWD_EXC_ILL_ADDR : 8'h00;

  // Diagnostics checks: length, sub-function range and zero data field.
  wire [7:0]  sub      = hdr_r[3];
  wire        sub_bad  = (hdr_r[2] != 8'h00) || (sub < `MWD_SUB_CLEAR) || (sub > `MWD_SUB_LAST);
  wire [7:0]  dg_exc   = BUSY_I ? `MWD_EXC_BUSY :
                         sub_bad ? `MWD_EXC_ILL_FUNC :
                         ((rx_cnt_r != `MWD_DIAG_LEN) || (diag_data != 16'h0)) ? `MWD_EXC_ILL_VALUE : 8'h00;
  wire [7:0]  end_exc  = is_wr ? wr_exc : dg_exc;
  wire        do_clear = for_us && is_dg && (dg_exc == 8'h00) && (sub == `MWD_SUB_CLEAR);
  wire [2:0]  cnt_sel  = 3'(sub - `MWD_SUB_FIRST_CNT);

  // Register map codes outside the permitted set fold into device failure.
  wire        reg_exc_ok = (REG_EXC_I == `MWD_EXC_ILL_FUNC) || (REG_EXC_I == `MWD_EXC_ILL_ADDR) ||
                           (REG_EXC_I == `MWD_EXC_ILL_VALUE) || (REG_EXC_I == `MWD_EXC_DEV_FAIL) ||
                           (REG_EXC_I == `MWD_EXC_BUSY);
  wire [7:0]  reg_exc    = reg_exc_ok ? REG_EXC_I : `MWD_EXC_DEV_FAIL;
  wire        wr_last    = ({9'h0, wr_idx_r} + 16'h1) == reg_count;
  wire        wr_done    = REG_WE_O && wr_issued_r;

  // Reply byte selection: exception replies are three bytes, normal ones six.
  wire        rep_exc   = (rep_code_r != 8'h00);
  wire [2:0]  rep_last  = rep_exc ? `MWD_EXC_LAST : `MWD_NORM_LAST;
  wire [7:0]  rep_byte  = (rep_idx_r == 3'h0) ? DEV_ADDR_I :
                          (rep_idx_r == 3'h1) ? (rep_exc ? (func | `MWD_EXC_FLAG) : func) :
                          (rep_idx_r == 3'h2) ? (rep_exc ? rep_code_r : hdr_r[2]) :
                          (rep_idx_r == 3'h3) ? hdr_r[3] :
                          (rep_idx_r == 3'h4) ? rep_val_r[15:8] : rep_val_r[7:0];
  wire        fifo_in_ready;
  wire        rep_push  = (state_r == MWD_REPLY) && fifo_in_ready;
  wire        rep_done  = rep_push && (rep_idx_r == rep_last);

  // Next state.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      MWD_RX:
        if (for_us && is_wr && (wr_exc == 8'h00))
          state_nxt = MWD_WRITE;
        else if (for_us && !bcast)
          state_nxt = MWD_REPLY;
      MWD_WRITE:
        if (wr_done)
          state_nxt = rep_bcast_r ? MWD_RX : MWD_REPLY;
      MWD_REPLY:
        if (rep_done)
          state_nxt = MWD_RX;
      default:
        state_nxt = MWD_RX;
    endcase
  end

  // Counter events; bytes of a frame arriving outside MWD_RX are dropped.
  always_comb
  begin
    cnt_inc                 = 8'h00;
    cnt_inc[MWD_CNT_BUS]    = end_ok;
    cnt_inc[MWD_CNT_COMM]   = end_bad || ((state_r == MWD_RX) && RX_ERR_I);
    cnt_inc[MWD_CNT_EXC]    = rep_done && rep_exc;
    cnt_inc[MWD_CNT_SRV]    = end_ok && addr_hit;
    cnt_inc[MWD_CNT_NORESP] = for_us && bcast;
    cnt_inc[MWD_CNT_NAK]    = 1'b0;
    cnt_inc[MWD_CNT_BUSY]   = rep_done && (rep_code_r == `MWD_EXC_BUSY);
    cnt_inc[MWD_CNT_OVR]    = end_ok && addr_hit && (ovr_seen_r || RX_OVR_I);
  end

  // Counters wrap to zero on overflow; a clear beats a same-cycle increment.
  for (genvar g = 0; g < 8; g++)
  begin : g_cnt
    always_ff @(posedge CLK_SYS_I)
    begin
      if (RESET_I || do_clear)
        cnt_r[g] <= 16'h0;
      else
        cnt_r[g] <= cnt_r[g] + 16'(cnt_inc[g]);
    end
  end

  // Frame reception into header and data buffer.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || frame_end)
      rx_cnt_r <= 8'h0;
    else if ((state_r == MWD_RX) && RX_VALID_I && (rx_cnt_r != 8'hff))
      rx_cnt_r <= rx_cnt_r + 8'h1;
  end

  // Header and data bytes; unused slots keep stale data, which no path reads.
  always_ff @(posedge CLK_SYS_I)
  begin
    if ((state_r == MWD_RX) && RX_VALID_I && (rx_cnt_r < `MWD_HDR_LEN))
      hdr_r[rx_cnt_r[2:0]] <= RX_DATA_I;
    if ((state_r == MWD_RX) && RX_VALID_I && (rx_cnt_r >= `MWD_HDR_LEN) &&
        (rx_cnt_r < 8'(BUF_BYTES) + `MWD_HDR_LEN))
      buf_r[rx_cnt_r - `MWD_HDR_LEN] <= RX_DATA_I;
  end

  // Overrun seen within the current frame.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || frame_end)
      ovr_seen_r <= 1'b0;
    else if (RX_OVR_I)
      ovr_seen_r <= 1'b1;
  end

  // Main state and reply bookkeeping.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      state_r     <= MWD_RX;
      rep_code_r  <= 8'h00;
      rep_val_r   <= 16'h0;
      rep_bcast_r <= 1'b0;
      rep_idx_r   <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (frame_end)
      begin
        rep_code_r  <= end_exc;
        rep_bcast_r <= bcast;
        rep_idx_r   <= 3'h0;
        rep_val_r   <= (is_dg && (sub != `MWD_SUB_CLEAR)) ? cnt_r[cnt_sel] : diag_data;
      end
      else if (REG_WE_O && (rep_code_r == 8'h00) && (REG_EXC_I != 8'h00))
        rep_code_r <= reg_exc;
      if (rep_push)
        rep_idx_r <= rep_idx_r + 3'h1;
    end
  end

  // Register writes, one register per cycle; the first error code is kept.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I || (state_r != MWD_WRITE))
    begin
      REG_WE_O    <= 1'b0;
      wr_idx_r    <= 7'h0;
      wr_issued_r <= 1'b0;
    end
    else if (!wr_issued_r)
    begin
      REG_WE_O    <= 1'b1;
      REG_ADDR_O  <= 16'(start_addr + {9'h0, wr_idx_r});
      REG_DATA_O  <= {buf_r[{wr_idx_r, 1'b0}], buf_r[{wr_idx_r, 1'b1}]};
      wr_idx_r    <= wr_idx_r + 7'h1;
      wr_issued_r <= wr_last;
    end
    else
      REG_WE_O <= 1'b0;
  end

  // Diagnostics register: sticky error flags, a new event beats the clear.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      diag_r <= 16'h0;
    else
    begin
      diag_r[`MWD_DIAG_COMM_BIT] <= cnt_inc[MWD_CNT_COMM] || (diag_r[`MWD_DIAG_COMM_BIT] && !do_clear);
      diag_r[`MWD_DIAG_OVR_BIT]  <= cnt_inc[MWD_CNT_OVR] || (diag_r[`MWD_DIAG_OVR_BIT] && !do_clear);
    end
  end
  assign DIAG_REG_O = diag_r;

  // Reply FIFO decouples the reply builder from a slow transmitter.
  mwd_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_SYS_I),
    .rst_i       (RESET_I),
    .in_valid_i  (state_r == MWD_REPLY),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({rep_idx_r == rep_last, rep_byte}),
    .out_valid_o (TX_VALID_O),
    .out_ready_i (TX_READY_I),
    .out_data_o  ({TX_LAST_O, TX_DATA_O})
  );

  // Checks.
  count_range_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    REG_WE_O |-> (reg_count != 16'h0) && (reg_count <= 16'(MAX_REGS)))
    else $error("register write with illegal count");
  exc_func_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    rep_push && rep_exc && (rep_idx_r == 3'h1) |-> rep_byte == (func | `MWD_EXC_FLAG))
    else $error("exception reply function byte wrong");
  exc_code_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    rep_push && rep_exc |-> rep_code_r inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h06})
    else $error("exception code outside permitted set");
  clear_cnt_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    do_clear |=> (cnt_r[0] == 16'h0) && (cnt_r[7] == 16'h0) &&
                 (diag_r == {14'h0, $past(cnt_inc[MWD_CNT_OVR]), $past(cnt_inc[MWD_CNT_COMM])}))
    else $error("clear left a counter set");
  bus_count_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    end_ok && !do_clear |=> cnt_r[0] == $past(cnt_r[0]) + 16'h1)
    else $error("bus counter missed a frame");
  bad_crc_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    end_bad |=> (state_r == MWD_RX) && (cnt_r[1] == $past(cnt_r[1]) + 16'h1))
    else $error("bad frame left receive state");
  byte_count_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    for_us && is_wr && bc_bad && !BUSY_I |=> rep_code_r == `MWD_EXC_ILL_VALUE)
    else $error("byte count mismatch not rejected");
  echo_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    rep_push && !rep_exc && is_wr && (rep_idx_r == 3'h5) |-> rep_done && (rep_byte == reg_count[7:0]))
    else $error("normal write reply tail wrong");
  wrap_a: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (cnt_r[3] == 16'hffff) && cnt_inc[3] && !do_clear |=> cnt_r[3] == 16'h0)
    else $error("counter did not wrap to zero");
  write_c: cover property (@(posedge CLK_SYS_I) wr_done && !rep_bcast_r);
  diag_c: cover property (@(posedge CLK_SYS_I) rep_done && !rep_exc && is_dg);
  exc_c: cover property (@(posedge CLK_SYS_I) rep_done && rep_exc);
  clear_c: cover property (@(posedge CLK_SYS_I) do_clear);
endmodule : mwd_server
`default_nettype wire

// ### verif/mwd_client.sv
// Modbus client model that sends request frames and sinks reply bytes.
`timescale 1ns/100ps
`default_nettype none
module mwd_client (
  // Clock.
  input  wire logic       clk_i,
  // Request bytes.
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_end_o,
  output logic            rx_crc_ok_o,
  output logic            rx_ovr_o,
  // Reply bytes.
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  output logic            tx_ready_o
);
  logic [7:0] got_q[$];
  logic       last_q[$];
  logic       stall = 1'b0;
  logic       slow = 1'b0;
  logic       ph = 1'b0;

  // All request lines start quiet.
  initial {rx_data_o, rx_valid_o, rx_end_o, rx_crc_ok_o, rx_ovr_o, tx_ready_o} = 13'h0;

  // A slow client takes every other byte; a stalled one lets the reply buffer fill.
  always @(negedge clk_i)
  begin
    ph <= ~ph;
    tx_ready_o <= ~stall & (~slow | ph);
  end

  // A byte is taken at the rising edge where valid meets ready.
  always @(posedge clk_i)
    if (tx_valid_i === 1'b1 && tx_ready_o)
    begin
      got_q.push_back(tx_data_i);
      last_q.push_back(tx_last_i);
    end

  // Idle data shows the inverse of the last byte, so a stale byte is never taken for a fresh one.
  task automatic send(input logic [7:0] fr[$], input logic crc_ok, input logic ovr);
    foreach (fr[i])
    begin
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = fr[i];
      rx_ovr_o = ovr && i == 1;
    end
    @(negedge clk_i);
    {rx_valid_o, rx_ovr_o, rx_end_o, rx_crc_ok_o} = {3'b001, crc_ok};
    rx_data_o = ~rx_data_o;
    @(negedge clk_i);
    {rx_end_o, rx_crc_ok_o} = {1'b0, ~crc_ok};
  endtask : send
endmodule : mwd_client
`default_nettype wire

// ### verif/tb.sv
// Self-checking testbench of the write-multiple and diagnostics request handler.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef logic [7:0] mwd_bytes_t[$];
  localparam logic [7:0] ADR = 8'h2c;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        busy = 1'b0;
  logic        rerr = 1'b0;
  logic [7:0]  exc_code = 8'h00;
  logic [7:0]  rdat, tdat;
  logic        rval, rend, rcrc, rovr, we, tval, trdy, tlast;
  logic [15:0] wadr, wdat, diag_reg;
  logic [31:0] wr_q[$];
  int          failures = 0;
  int          cmp_count = 0;

  // The register map answers in the strobe cycle.
  wire logic [7:0] rexc = we ? exc_code : 8'h00;

  // 200 MHz system clock.
  always #2.5 clk = ~clk;

  mwd_server u_mwd_server (
    .CLK_SYS_I(clk), .RESET_I(rst), .DEV_ADDR_I(ADR), .BUSY_I(busy),
    .RX_DATA_I(rdat), .RX_VALID_I(rval), .RX_END_I(rend), .RX_CRC_OK_I(rcrc),
    .RX_ERR_I(rerr), .RX_OVR_I(rovr), .REG_WE_O(we), .REG_ADDR_O(wadr),
    .REG_DATA_O(wdat), .REG_EXC_I(rexc), .TX_VALID_O(tval), .TX_READY_I(trdy),
    .TX_DATA_O(tdat), .TX_LAST_O(tlast), .DIAG_REG_O(diag_reg)
  );

  mwd_client u_mwd_client (
    .clk_i(clk), .rx_data_o(rdat), .rx_valid_o(rval), .rx_end_o(rend),
    .rx_crc_ok_o(rcrc), .rx_ovr_o(rovr), .tx_valid_i(tval), .tx_data_i(tdat),
    .tx_last_i(tlast), .tx_ready_o(trdy)
  );

  // Every register strobe is logged for comparison after the reply.
  always @(posedge clk)
    if (we === 1'b1)
      wr_q.push_back({wadr, wdat});

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic mwd_bytes_t wr_frame(logic [7:0] a, logic [15:0] s, logic [15:0] n, logic [7:0] bc, int nd);
    mwd_bytes_t f;
    f = {a, 8'h10, s[15:8], s[7:0], n[15:8], n[7:0], bc};
    for (int i = 0; i < nd; i++)
      f.push_back(8'h30 + 8'(i));
    return f;
  endfunction : wr_frame

  // Waits a bounded time for the reply, then a little more so extra bytes show up.
  task automatic expect_reply(input mwd_bytes_t exp, input int plen);
    int n;
    n = 0;
    while (u_mwd_client.got_q.size() < exp.size() && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    chk(u_mwd_client.got_q.size(), exp.size(), "reply length");
    foreach (exp[i])
      if (i < u_mwd_client.got_q.size())
      begin
        chk(u_mwd_client.got_q[i], exp[i], "reply byte");
        chk(u_mwd_client.last_q[i], (i + 1) % plen == 0, "last flag");
      end
    u_mwd_client.got_q.delete();
    u_mwd_client.last_q.delete();
  endtask : expect_reply

  task automatic quiet(input logic none);
    repeat (40) @(posedge clk);
    if (none)
      chk(u_mwd_client.got_q.size(), 0, "unexpected reply");
    u_mwd_client.got_q.delete();
    u_mwd_client.last_q.delete();
  endtask : quiet

  task automatic diag(input logic [7:0] sub, input logic [15:0] val, input logic [15:0] ev);
    u_mwd_client.send({ADR, 8'h08, 8'h00, sub, val[15:8], val[7:0]}, 1'b1, 1'b0);
    expect_reply({ADR, 8'h08, 8'h00, sub, ev[15:8], ev[7:0]}, 6);
  endtask : diag

  task automatic do_write(input logic [15:0] s, input logic [15:0] n);
    u_mwd_client.send(wr_frame(ADR, s, n, {n[6:0], 1'b0}, 2 * int'(n)), 1'b1, 1'b0);
    expect_reply({ADR, 8'h10, s[15:8], s[7:0], n[15:8], n[7:0]}, 6);
    chk(wr_q.size(), n, "write count");
    foreach (wr_q[i])
      chk(wr_q[i], {s + 16'(i), 8'h30 + 8'(2 * i), 8'h31 + 8'(2 * i)}, "write word");
    wr_q.delete();
  endtask : do_write

  // Two registers to a slow client, then the largest run ending on the top address.
  task automatic t_write();
    u_mwd_client.slow = 1'b1;
    do_write(16'h0040, 16'd2);
    u_mwd_client.slow = 1'b0;
    do_write(16'hff85, 16'd123);
  endtask : t_write

  task automatic t_exc();
    logic [15:0] s [8] = '{16'h0, 16'h0, 16'h0, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] n [8] = '{16'd124, 16'd0, 16'd1, 16'd2, 16'd1, 16'd1, 16'd1, 16'd1};
    logic [7:0] bc [8] = '{8'hf8, 8'h0, 8'h3, 8'h4, 8'h2, 8'h2, 8'h2, 8'h2};
    logic [7:0] rx [8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h4, 8'h1, 8'h5};
    logic [7:0] code [8] = '{8'h3, 8'h3, 8'h3, 8'h2, 8'h6, 8'h4, 8'h1, 8'h4};
    foreach (s[i])
    begin
      @(negedge clk);
      busy = i == 4;
      exc_code = rx[i];
      u_mwd_client.send(wr_frame(ADR, s[i], n[i], bc[i], i ? int'(bc[i]) : 0), 1'b1, 1'b0);
      expect_reply({ADR, 8'h90, code[i]}, 3);
    end
    @(negedge clk);
    {busy, exc_code} = 9'h0;
    wr_q.delete();
  endtask : t_exc

  task automatic t_errs();
    diag(8'h0a, 16'h0, 16'h0);
    @(negedge clk);
    rerr = 1'b1;
    @(negedge clk);
    rerr = 1'b0;
    u_mwd_client.send({ADR, 8'h08, 8'h00, 8'h0c, 8'h00, 8'h00}, 1'b0, 1'b0);
    quiet(1'b1);
    chk(diag_reg[0], 1'b1, "comm error flag");
    diag(8'h0c, 16'h0, 16'h2);
  endtask : t_errs

  // Counts are snapshots taken before each read's own increments.
  task automatic t_counts();
    logic [7:0] sub [7] = '{8'h0b, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h0c, 8'h12};
    logic [15:0] exv [7] = '{16'h3, 16'h1, 16'h4, 16'h0, 16'h1, 16'h0, 16'h0};
    diag(8'h0a, 16'h0, 16'h0);
    u_mwd_client.send(wr_frame(ADR + 8'h1, 16'h0, 16'h1, 8'h2, 2), 1'b1, 1'b0);
    quiet(1'b1);
    do_write(16'h0100, 16'd1);
    @(negedge clk);
    busy = 1'b1;
    u_mwd_client.send(wr_frame(ADR, 16'h0, 16'h1, 8'h2, 2), 1'b1, 1'b0);
    expect_reply({ADR, 8'h90, 8'h06}, 3);
    chk(wr_q.size(), 0, "write while busy");
    @(negedge clk);
    busy = 1'b0;
    foreach (sub[i])
      diag(sub[i], 16'h0, exv[i]);
    wr_q.delete();
  endtask : t_counts

  task automatic t_bcast();
    diag(8'h0a, 16'h0, 16'h0);
    u_mwd_client.send(wr_frame(8'h00, 16'h0200, 16'h1, 8'h2, 2), 1'b1, 1'b0);
    quiet(1'b1);
    chk(wr_q.size(), 1, "broadcast write");
    diag(8'h0f, 16'h0, 16'h1);
    wr_q.delete();
  endtask : t_bcast

  task automatic t_ovr();
    diag(8'h0a, 16'h0, 16'h0);
    u_mwd_client.send({ADR, 8'h08, 8'h00, 8'h12, 8'h00, 8'h00}, 1'b1, 1'b1);
    quiet(1'b0);
    chk(diag_reg[1], 1'b1, "overrun flag");
    diag(8'h12, 16'h0, 16'h1);
    diag(8'h0a, 16'h0, 16'h0);
    chk(diag_reg, 16'h0, "diagnostics register");
    diag(8'h0b, 16'h0, 16'h0);
  endtask : t_ovr

  task automatic t_diag_bad();
    u_mwd_client.send({ADR, 8'h08, 8'h00, 8'h13, 8'h00, 8'h00}, 1'b1, 1'b0);
    expect_reply({ADR, 8'h88, 8'h01}, 3);
    u_mwd_client.send({ADR, 8'h08, 8'h01, 8'h0b, 8'h00, 8'h00}, 1'b1, 1'b0);
    expect_reply({ADR, 8'h88, 8'h01}, 3);
    u_mwd_client.send({ADR, 8'h08, 8'h00, 8'h0b, 8'h00, 8'h01}, 1'b1, 1'b0);
    expect_reply({ADR, 8'h88, 8'h03}, 3);
  endtask : t_diag_bad

  // Three replies overfill the 16-byte buffer while the client stalls.
  task automatic t_fifo();
    mwd_bytes_t one = {ADR, 8'h08, 8'h00, 8'h10, 8'h00, 8'h00};
    u_mwd_client.stall = 1'b1;
    repeat (3)
    begin
      u_mwd_client.send(one, 1'b1, 1'b0);
      repeat (20) @(posedge clk);
    end
    chk(u_mwd_client.got_q.size(), 0, "bytes while stalled");
    u_mwd_client.stall = 1'b0;
    expect_reply({one, one, one}, 6);
  endtask : t_fifo

  task automatic results();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // A hang is cut short well beyond the roughly 1500 cycles the run needs.
  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end

  // Main sequence.
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_write();
    t_exc();
    t_errs();
    t_counts();
    t_bcast();
    t_ovr();
    t_diag_bad();
    t_fifo();
    results();
  end
endmodule : tb
`default_nettype wire
